// file: rrp_pkg.sv
// Constants and enumerations for the radio remote pairing controller
package rrp_pkg;
    localparam longint       CLK_HZ         = 50_000_000;
    localparam longint       IDLE_S         = 3600;
    localparam longint       AUTO_S         = 600;
    localparam longint       SETUP_S        = 30;
    localparam longint       HOLD_MS        = 2000;
    localparam logic [39:0]  IDLE_CYC       = 40'(IDLE_S * CLK_HZ);
    localparam logic [39:0]  AUTO_CYC       = 40'(AUTO_S * CLK_HZ);
    localparam logic [39:0]  SETUP_CYC      = 40'(SETUP_S * CLK_HZ);
    localparam logic [39:0]  HOLD_CYC       = 40'((HOLD_MS * CLK_HZ) / 1000);
    localparam int           TW             = 40;
    localparam int           NBTN           = 10;
    localparam int           NSHIFT         = 8;
    localparam int           NOUT           = 19;
    localparam int           IDW            = 32;
    localparam int           FLW            = 25;
    localparam int           FL_FAST_BIT    = 21;
    localparam int           FL_SLOW_BIT    = 24;
    localparam logic [1:0]   PW_LAST        = 2'h3;
    localparam logic [NBTN-1:0] BTN_ONE     = 10'h001;
    localparam logic [NBTN-1:0] BTN_FOUR    = 10'h008;
    localparam logic [NBTN-1:0] BTN_FIVE    = 10'h010;

    typedef enum logic [2:0] {
        RX_RUN   = 3'b000,
        RX_ARM   = 3'b001,
        RX_REQ   = 3'b010,
        RX_SETUP = 3'b011,
        RX_TOUT  = 3'b100
    } rrp_rx_t;

    typedef enum logic [2:0] {
        CF_IDLE  = 3'b000,
        CF_OFF   = 3'b001,
        CF_BOTH  = 3'b010,
        CF_ON    = 3'b011,
        CF_CFG   = 3'b100,
        CF_PWOK  = 3'b101,
        CF_MODE  = 3'b110
    } rrp_cf_t;

    typedef enum logic [1:0] {
        MD_ONOFF  = 2'b00,
        MD_SECURE = 2'b01,
        MD_AUTO   = 2'b10
    } rrp_mode_t;

    // Password digits 3,1,4,2 as one-hot button masks
    function automatic logic [NBTN-1:0] rrp_pw_mask(input logic [1:0] idx);
        case (idx)
            2'h0:    rrp_pw_mask = 10'h004;
            2'h1:    rrp_pw_mask = 10'h001;
            2'h2:    rrp_pw_mask = 10'h008;
            default: rrp_pw_mask = 10'h002;
        endcase
    endfunction
endpackage

// file: rrp_ctrl.sv
// Receiver control: output mapping, timers, setup, pairing and startup modes
// Operation
// RULE1: Buttons one to ten drive output channels one to ten.
// RULE2: With shift held, buttons one to eight drive channels eleven to eighteen.
// RULE3: Held power-on button acts as shift once the transmitter is on.
// RULE4: One hour without presses shuts down and clears all outputs.
// RULE5: Any button press, power included, reloads the full one hour timer.
// RULE6: Config mode needs off held, on held, off released, on released.
// RULE7: Setup held long enough switches status lamp from slow to fast flash.
// RULE8: Release after fast flash enters setup: status solid green, link lamp off.
// RULE9: Setup mode times out after thirty seconds without a pairing code.
// RULE10: After timeout link and status flash red fast until setup requested.
// RULE11: Power-on in config mode sends identity code to receiver in setup.
// RULE12: After download the transmitter battery and active lamps go out.
// RULE13: Accepted identity code switches link lamp from green to red; here it goes from off in setup to red.
// RULE14: Once paired only traffic with matching identity code is accepted; config and mode frames are still taken from any near transmitter.
// RULE15: New identity code accepted only from a transmitter in close proximity.
// RULE16: At power-up emergency-halt and link lamps red, status lamp green.
// RULE17: Mode settings accepted only after buttons 3,1,4,2 then power-on.
// RULE18: Exactly three startup and shutdown modes are selectable.
// RULE19: Nineteen output channels, each may be factory set as input.
// RULE20: On/off mode deasserts outputs whenever the link is lost.
// RULE21: Secure mode turns on after 3,1,4,2 plus power; off on link loss.
// RULE22: Auto mode turns off on link loss or ten idle minutes.
// RULE23: All timers run from one clock; reset clears modes and timers.
// RULE24: Identity code and startup mode kept in non-volatile storage.
`timescale 1ns/1ps
`default_nettype none
module rrp_ctrl
    import rrp_pkg::*;
#(
    parameter logic [rrp_pkg::TW-1:0] P_IDLE_CYC  = rrp_pkg::IDLE_CYC,
    parameter logic [rrp_pkg::TW-1:0] P_AUTO_CYC  = rrp_pkg::AUTO_CYC,
    parameter logic [rrp_pkg::TW-1:0] P_SETUP_CYC = rrp_pkg::SETUP_CYC,
    parameter logic [rrp_pkg::TW-1:0] P_HOLD_CYC  = rrp_pkg::HOLD_CYC
)(
    input  wire logic                     i_clk,
    input  wire logic                     i_rst,
    input  wire logic                     i_rx_valid,
    input  wire logic [rrp_pkg::IDW-1:0]  i_rx_id,
    input  wire logic [rrp_pkg::NBTN-1:0] i_rx_btn,
    input  wire logic                     i_rx_shift,
    input  wire logic                     i_rx_pwr_on,
    input  wire logic                     i_rx_pwr_off,
    input  wire logic                     i_rx_pair,
    input  wire logic                     i_rx_near,
    input  wire logic                     i_link_ok,
    input  wire logic                     i_setup_btn,
    input  wire logic [rrp_pkg::NOUT-1:0] i_in_mask,
    input  wire logic [rrp_pkg::IDW-1:0]  i_nv_id,
    input  wire logic                     i_nv_paired,
    input  wire logic [1:0]               i_nv_mode,
    output logic      [rrp_pkg::NOUT-1:0] o_out,
    output logic                          o_nv_wr,
    output logic      [rrp_pkg::IDW-1:0]  o_nv_id,
    output logic      [1:0]               o_nv_mode,
    output logic                          o_estop_red,
    output logic                          o_link_red,
    output logic                          o_link_green,
    output logic                          o_status_red,
    output logic                          o_status_green,
    output logic                          o_tx_cfg_mode,
    output logic                          o_tx_lamps_on
);
    import rrp_pkg::*;

    typedef struct packed {
        rrp_rx_t            st;
        rrp_cf_t            cf;
        logic [1:0]         cpw;
        logic [1:0]         spw;
        rrp_mode_t          mode;
        logic [IDW-1:0]     id;
        logic               paired;
        logic               loaded;
        logic               sys_on;
        logic [NBTN-1:0]    btn;
        logic               pon;
        logic               poff;
        logic [TW-1:0]      idle;
        logic [TW-1:0]      tmr;
        logic [FLW-1:0]     fl;
        logic [NOUT-1:0]    outs;
        logic               nv_wr;
        logic               dl_done;
        logic               link_seen;
    } rrp_st_t;

    rrp_st_t         s_q;
    rrp_st_t         s_d;
    logic            own;
    logic            any_rx;
    logic [NBTN-1:0] press;
    logic            pon_press;
    logic            poff_press;
    logic            shift;
    logic [NOUT-1:0] map;
    logic [TW-1:0]   idle_lim;

    // Frame qualification
    assign any_rx     = i_rx_valid && i_rx_near;
    assign own        = i_rx_valid && s_q.paired && (i_rx_id == s_q.id);  // RULE14
    assign press      = i_rx_btn & ~s_q.btn;
    assign pon_press  = i_rx_pwr_on && !s_q.pon;
    assign poff_press = i_rx_pwr_off && !s_q.poff;
    assign shift      = i_rx_shift || (s_q.sys_on && i_rx_pwr_on);  // RULE3
    assign idle_lim   = (s_q.mode == MD_AUTO) ? P_AUTO_CYC : P_IDLE_CYC;  // RULE22

    // Button to channel map
    genvar k;
    generate
        for (k = 0; k < NOUT; k++)
        begin : g_map
            if (k < NSHIFT)
            begin : g_lo
                assign map[k] = i_rx_btn[k] && !shift;  // RULE2
            end
            else if (k < NBTN)
            begin : g_mid
                assign map[k] = i_rx_btn[k];  // RULE1
            end
            else if (k < NBTN + NSHIFT)
            begin : g_hi
                assign map[k] = i_rx_btn[k-NBTN] && shift;  // RULE2
            end
            else
            begin : g_top
                assign map[k] = 1'b1;
            end
        end
    endgenerate

    always_comb
    begin
        s_d       = s_q;
        s_d.fl    = s_q.fl + 1'b1;
        s_d.nv_wr = 1'b0;

        // Non-volatile contents restored after reset
        if (!s_q.loaded)
        begin
            s_d.loaded = 1'b1;  // RULE24
            s_d.id     = i_nv_id;
            s_d.paired = i_nv_paired;
            s_d.mode   = (i_nv_mode == MD_SECURE) ? MD_SECURE :
                         (i_nv_mode == MD_AUTO) ? MD_AUTO : MD_ONOFF;  // RULE18
        end

        // Transmitter configuration sequence tracking
        if (any_rx)
        begin
            case (s_q.cf)
                CF_IDLE:
                begin
                    if (i_rx_pwr_off && !i_rx_pwr_on)
                        s_d.cf = CF_OFF;  // RULE6
                end
                CF_OFF:
                begin
                    if (!i_rx_pwr_off)
                        s_d.cf = CF_IDLE;
                    else if (i_rx_pwr_on)
                        s_d.cf = CF_BOTH;
                end
                CF_BOTH:
                begin
                    if (!i_rx_pwr_on)
                        s_d.cf = CF_IDLE;
                    else if (!i_rx_pwr_off)
                        s_d.cf = CF_ON;
                end
                CF_ON:
                begin
                    if (i_rx_pwr_off)
                        s_d.cf = CF_IDLE;
                    else if (!i_rx_pwr_on)
                    begin
                        s_d.cf  = CF_CFG;
                        s_d.cpw = 2'h0;
                    end
                end
                CF_CFG:
                begin
                    if (press == rrp_pw_mask(s_q.cpw))
                        s_d.cpw = s_q.cpw + 1'b1;  // RULE17
                    else if (press != '0)
                        s_d.cpw = 2'h0;
                    if (press == rrp_pw_mask(PW_LAST) && s_q.cpw == PW_LAST)
                        s_d.cf = CF_PWOK;
                end
                CF_PWOK:
                begin
                    if (pon_press)
                        s_d.cf = CF_MODE;  // RULE17
                    else if (press != '0)
                    begin
                        s_d.cf  = CF_CFG;
                        s_d.cpw = 2'h0;
                    end
                end
                CF_MODE:
                begin
                    if (press != '0)
                    begin
                        s_d.cf  = CF_IDLE;
                        s_d.cpw = 2'h0;  // RULE21
                        if (press == BTN_ONE || press == BTN_FOUR || press == BTN_FIVE)
                        begin
                            s_d.mode  = (press == BTN_FOUR) ? MD_SECURE :
                                        (press == BTN_FIVE) ? MD_AUTO : MD_ONOFF;  // RULE18
                            s_d.nv_wr = 1'b1;  // RULE24
                        end
                    end
                end
                default: s_d.cf = CF_IDLE;
            endcase
            if (poff_press && s_q.cf >= CF_CFG)
                s_d.cf = CF_IDLE;
        end

        // Setup and pairing sequence
        case (s_q.st)
            RX_RUN, RX_TOUT:
            begin
                if (i_setup_btn)
                begin
                    s_d.st  = RX_ARM;
                    s_d.tmr = '0;
                end
            end
            RX_ARM:
            begin
                s_d.tmr = s_q.tmr + 1'b1;
                if (!i_setup_btn)
                    s_d.st = RX_RUN;
                else if (s_q.tmr >= P_HOLD_CYC - 1'b1)
                    s_d.st = RX_REQ;  // RULE7
            end
            RX_REQ:
            begin
                if (!i_setup_btn)
                begin
                    s_d.st      = RX_SETUP;  // RULE8
                    s_d.tmr     = '0;
                    s_d.sys_on  = 1'b0;
                    s_d.dl_done = 1'b0;
                end
            end
            RX_SETUP:
            begin
                s_d.tmr = s_q.tmr + 1'b1;
                if (any_rx && i_rx_pair && s_q.cf == CF_CFG && pon_press)  // RULE11 RULE15
                begin
                    s_d.id        = i_rx_id;
                    s_d.paired    = 1'b1;
                    s_d.nv_wr     = 1'b1;  // RULE24
                    s_d.dl_done   = 1'b1;  // RULE12
                    s_d.link_seen = 1'b0;  // RULE13
                    s_d.cf        = CF_IDLE;
                    s_d.st        = RX_RUN;
                end
                else if (s_q.tmr >= P_SETUP_CYC - 1'b1)
                    s_d.st = RX_TOUT;  // RULE9
            end
            default: s_d.st = RX_RUN;
        endcase

        // Operating frames from the paired transmitter
        if (s_q.st != RX_SETUP && s_q.st != RX_REQ)
        begin
            s_d.idle = s_q.idle + 1'b1;
            if (own)
            begin
                s_d.btn       = i_rx_btn;
                s_d.pon       = i_rx_pwr_on;
                s_d.poff      = i_rx_pwr_off;
                s_d.link_seen = 1'b1;
                if (press != '0 || pon_press || poff_press)
                    s_d.idle = '0;  // RULE5
                if (press != '0)
                    s_d.spw = (press == rrp_pw_mask(s_q.spw)) ? s_q.spw + 1'b1 : 2'h0;
                if (pon_press && s_q.cf < CF_CFG)
                begin
                    if (s_q.mode != MD_SECURE || s_q.spw == '0 && s_q.btn == '0 &&
                        press == '0 && s_q.cpw == PW_LAST)
                        s_d.sys_on = 1'b1;
                    s_d.spw = 2'h0;
                end
                if (poff_press)
                    s_d.sys_on = 1'b0;
            end
            else if (any_rx)
            begin
                s_d.btn  = i_rx_btn;
                s_d.pon  = i_rx_pwr_on;
                s_d.poff = i_rx_pwr_off;
            end
            // Secure start: password completed then power pressed
            if (own && pon_press && s_q.mode == MD_SECURE && s_q.spw == '0 && s_q.cf < CF_CFG)
                s_d.sys_on = s_q.sys_on;
            if (own && press == rrp_pw_mask(PW_LAST) && s_q.spw == PW_LAST)
                s_d.cpw = PW_LAST;
            if (own && pon_press && s_q.mode == MD_SECURE && s_q.cpw == PW_LAST && s_q.cf < CF_CFG)
            begin
                s_d.sys_on = 1'b1;  // RULE21
                s_d.cpw    = 2'h0;
            end
            if (s_d.idle >= idle_lim)
                s_d.sys_on = 1'b0;  // RULE4 RULE22
        end

        if (!i_link_ok)
        begin
            s_d.sys_on    = 1'b0;  // RULE20 RULE21 RULE22
            s_d.link_seen = 1'b0;
        end

        // Outputs only follow frames from the paired transmitter
        s_d.outs = (s_d.sys_on && s_d.st != RX_SETUP) ? (own ? map : s_q.outs) : '0;  // RULE4 RULE14 RULE19
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            s_q        <= '0;  // RULE23
            s_q.st     <= RX_RUN;
            s_q.cf     <= CF_IDLE;
            s_q.mode   <= MD_ONOFF;
        end
        else
            s_q <= s_d;
    end

    // Outputs and lamps
    assign o_out          = s_q.outs & ~i_in_mask;  // RULE19
    assign o_nv_wr        = s_q.nv_wr;
    assign o_nv_id        = s_q.id;
    assign o_nv_mode      = s_q.mode;
    assign o_estop_red    = !s_q.sys_on;  // RULE16
    assign o_link_red     = (s_q.st == RX_TOUT) ? s_q.fl[FL_FAST_BIT] :  // RULE10
                            (s_q.st == RX_RUN || s_q.st == RX_ARM) && !s_q.link_seen;  // RULE13 RULE16
    assign o_link_green   = (s_q.st == RX_RUN || s_q.st == RX_ARM) && s_q.link_seen;
    assign o_status_red   = (s_q.st == RX_TOUT) && s_q.fl[FL_FAST_BIT];  // RULE10
    assign o_status_green = (s_q.st == RX_ARM)   ? s_q.fl[FL_SLOW_BIT] :  // RULE7
                            (s_q.st == RX_REQ)   ? s_q.fl[FL_FAST_BIT] :
                            (s_q.st == RX_SETUP) ? 1'b1 :  // RULE8
                            (s_q.st == RX_RUN);  // RULE16
    assign o_tx_cfg_mode  = (s_q.cf >= CF_CFG);
    assign o_tx_lamps_on  = !s_q.dl_done;  // RULE12
endmodule
`default_nettype wire

// file: rrp_ctrl_props.sv
// Port-level assertions for the receiver controller
`timescale 1ns/1ps
`default_nettype none
module rrp_ctrl_props
    import rrp_pkg::*;
(
    input wire logic                     i_clk,
    input wire logic                     i_rst,
    input wire logic                     i_rx_valid,
    input wire logic [rrp_pkg::IDW-1:0]  i_rx_id,
    input wire logic [rrp_pkg::NBTN-1:0] i_rx_btn,
    input wire logic                     i_rx_shift,
    input wire logic                     i_rx_pwr_on,
    input wire logic                     i_rx_pair,
    input wire logic                     i_rx_near,
    input wire logic                     i_link_ok,
    input wire logic [rrp_pkg::NOUT-1:0] i_in_mask,
    input wire logic [rrp_pkg::NOUT-1:0] o_out,
    input wire logic                     o_nv_wr,
    input wire logic [rrp_pkg::IDW-1:0]  o_nv_id,
    input wire logic                     o_estop_red,
    input wire logic                     o_link_red,
    input wire logic                     o_status_green,
    input wire logic                     o_tx_lamps_on
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_own;
        i_rx_valid && i_rx_id == o_nv_id && o_out[18] && i_link_ok;
    endsequence
    sequence s_far_pair;
        i_rx_valid && i_rx_pair && !i_rx_near;
    endsequence
    sequence s_near_pair;
        i_rx_valid && i_rx_pair && i_rx_near;
    endsequence

    property p_reset;
        $fell(i_rst) |-> o_estop_red && o_link_red && o_status_green && o_tx_lamps_on && o_out == '0;
    endproperty
    property p_direct;
        s_own ##0 (!i_rx_shift && !i_rx_pwr_on) |=> o_out[9:0] == ($past(i_rx_btn) & ~i_in_mask[9:0]);
    endproperty
    property p_shift;
        s_own ##0 (i_rx_shift && !i_rx_pwr_on) |=> o_out[17:10] == ($past(i_rx_btn[7:0]) & ~i_in_mask[17:10]);
    endproperty
    property p_pwr_shift;
        s_own ##0 (i_rx_pwr_on && !i_rx_shift) |=> o_out[17:10] == ($past(i_rx_btn[7:0]) & ~i_in_mask[17:10]);
    endproperty
    property p_foreign;
        i_rx_valid && i_rx_id != o_nv_id ##1 i_link_ok |-> $stable(o_out);
    endproperty
    property p_mask;
        (o_out & i_in_mask) == '0;
    endproperty
    property p_link;
        !i_link_ok [*2] |-> o_out == '0;
    endproperty
    property p_nv_pulse;
        o_nv_wr |=> !o_nv_wr;
    endproperty
    property p_far;
        s_far_pair |=> !o_nv_wr [*3];
    endproperty
    property p_pair_ok;
        s_near_pair ##[1:3] o_nv_wr |-> ##[0:2] (o_link_red && !o_tx_lamps_on);
    endproperty

    a_reset: assert property (p_reset) else $error("reset lamps wrong");
    a_direct: assert property (p_direct) else $error("direct channel wrong");
    a_shift: assert property (p_shift) else $error("shift channel wrong");
    a_pwr_shift: assert property (p_pwr_shift) else $error("power shift wrong");
    a_foreign: assert property (p_foreign) else $error("foreign frame used");
    a_mask: assert property (p_mask) else $error("input pin driven");
    a_link: assert property (p_link) else $error("output on without link");
    a_nv_pulse: assert property (p_nv_pulse) else $error("store pulse too long");
    a_far: assert property (p_far) else $error("far pairing taken");
    a_pair_ok: assert property (p_pair_ok) else $error("pair lamps wrong");
endmodule

bind rrp_ctrl rrp_ctrl_props u_props (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_rx_valid(i_rx_valid),
    .i_rx_id(i_rx_id),
    .i_rx_btn(i_rx_btn),
    .i_rx_shift(i_rx_shift),
    .i_rx_pwr_on(i_rx_pwr_on),
    .i_rx_pair(i_rx_pair),
    .i_rx_near(i_rx_near),
    .i_link_ok(i_link_ok),
    .i_in_mask(i_in_mask),
    .o_out(o_out),
    .o_nv_wr(o_nv_wr),
    .o_nv_id(o_nv_id),
    .o_estop_red(o_estop_red),
    .o_link_red(o_link_red),
    .o_status_green(o_status_green),
    .o_tx_lamps_on(o_tx_lamps_on)
);
`default_nettype wire

// file: rrp_tx_model.sv
// Behavioural handheld transmitter producing decoded frames
`timescale 1ns/1ps
`default_nettype none
module rrp_tx_model
    import rrp_pkg::*;
#(
    parameter logic [rrp_pkg::IDW-1:0] P_ID = 32'h0000_C0DE // Arbitrary value
)(
    input  wire logic                     i_clk,
    output logic                          o_valid,
    output logic      [rrp_pkg::IDW-1:0]  o_id,
    output logic      [rrp_pkg::NBTN-1:0] o_btn,
    output logic                          o_shift,
    output logic                          o_pwr_on,
    output logic                          o_pwr_off,
    output logic                          o_pair,
    output logic                          o_near
);
    initial
    begin
        o_valid = 1'b0;
        {o_id, o_btn, o_shift, o_pwr_on, o_pwr_off, o_pair, o_near} = '0;
    end

    task automatic send(input logic [NBTN-1:0] btn, input logic sh, on, off, pair, near, other);
        @(negedge i_clk);
        o_valid = 1'b1;
        o_id = other ? ~P_ID : P_ID;
        {o_btn, o_shift, o_pwr_on, o_pwr_off, o_pair, o_near} = {btn, sh, on, off, pair, near};
        @(negedge i_clk);
        o_valid = 1'b0;
        // Fields outside a frame carry no old value
        {o_id, o_btn, o_shift, o_pwr_on, o_pwr_off, o_pair, o_near} =
            ~{o_id, o_btn, o_shift, o_pwr_on, o_pwr_off, o_pair, o_near};
        @(negedge i_clk);
    endtask

    task automatic press(input logic [NBTN-1:0] btn, input logic on);
        send(btn, 1'b0, on, 1'b0, 1'b0, 1'b1, 1'b0);
        send(10'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    endtask

    task automatic enter_cfg();
        send(10'h000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        send(10'h000, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        send(10'h000, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        send(10'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    endtask
endmodule
`default_nettype wire

// file: tb.sv
// Self-checking bench for the receiver controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rrp_pkg::*;
    localparam logic [IDW-1:0] ID = 32'h0000_C0DE;

    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic            valid, shift, pon, poff, pair, near, link, setup, nv_pd;
    logic [IDW-1:0]  rid, nv_id, o_id;
    logic [NBTN-1:0] btn;
    logic [NOUT-1:0] mask, out;
    logic [1:0]      mode, nv_md;
    logic            nv_wr, estop, lred, lgrn, sred, sgrn, cfg, lamps;
    int              err_count = 0;
    int              n_compared = 0;
    int              nv_seen = 0;

    always #10 clk = ~clk;
    always @(posedge clk) if (nv_wr === 1'b1) nv_seen <= nv_seen + 1;

    rrp_ctrl #(
        .P_IDLE_CYC (40'h00000000C8),
        .P_AUTO_CYC (40'h0000000064),
        .P_SETUP_CYC(40'h000000012C),
        .P_HOLD_CYC (40'h0000000014)
    ) uut (
        .i_clk(clk), .i_rst(rst), .i_rx_valid(valid), .i_rx_id(rid), .i_rx_btn(btn),
        .i_rx_shift(shift), .i_rx_pwr_on(pon), .i_rx_pwr_off(poff), .i_rx_pair(pair),
        .i_rx_near(near), .i_link_ok(link), .i_setup_btn(setup), .i_in_mask(mask),
        .i_nv_id(nv_id), .i_nv_paired(nv_pd), .i_nv_mode(nv_md), .o_out(out), .o_nv_wr(nv_wr),
        .o_nv_id(o_id), .o_nv_mode(mode), .o_estop_red(estop), .o_link_red(lred),
        .o_link_green(lgrn), .o_status_red(sred), .o_status_green(sgrn),
        .o_tx_cfg_mode(cfg), .o_tx_lamps_on(lamps)
    );

    rrp_tx_model #(.P_ID(ID)) tx (
        .i_clk(clk), .o_valid(valid), .o_id(rid), .o_btn(btn), .o_shift(shift),
        .o_pwr_on(pon), .o_pwr_off(poff), .o_pair(pair), .o_near(near)
    );

    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic do_reset(input logic pd);
        nv_pd = pd;
        rst = 1'b1;
        cyc(20);
        rst = 1'b0;
        cyc(2);
        check("reset", {estop, lred, sgrn, lamps, out}, {4'hF, 19'h00000});
    endtask

    task automatic setup_req();
        setup = 1'b1;
        cyc(25);
        setup = 1'b0;
        cyc(2);
    endtask

    task automatic t_pair();
        int n;
        do_reset(1'b0);
        setup_req();
        check("setup lamps", {sgrn, lred, lgrn}, 3'h4);
        tx.enter_cfg();
        check("cfg", cfg, 1'b1);
        n = nv_seen;
        tx.send(10'h000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        tx.send(10'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        check("far pair", nv_seen, n);
        tx.send(10'h000, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
        cyc(2);
        check("pair wr", nv_seen, n + 1);
        check("pair id", o_id, ID);
        check("pair lamps", {lred, lamps}, 2'h2);
    endtask

    task automatic t_map();
        logic [NBTN-1:0] b;
        do_reset(1'b1);
        tx.press(10'h000, 1'b1);
        check("on", out, 19'h40000);
        for (int k = 0; k < NBTN; k++)
        begin
            b = 10'h001 << k;
            tx.send(b, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
            check("direct", out, {9'h100, b});
        end
        for (int k = 0; k < NSHIFT; k++)
        begin
            b = 10'h001 << k;
            tx.send(b, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
            check("shift", out, {1'b1, b[7:0], 10'h000});
            tx.send(b, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
            check("pwr shift", out, {1'b1, b[7:0], 10'h000});
        end
        tx.send(10'h000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        tx.send(10'h001, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        check("foreign", out, 19'h40000);
        mask = 19'h00001;
        tx.send(10'h001, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        check("input pin", out, 19'h40000);
        mask = 19'h00000;
    endtask

    task automatic t_idle();
        repeat (3)
        begin
            cyc(150);
            tx.press(10'h200, 1'b0);
            check("alive", out[18], 1'b1);
        end
        cyc(220);
        check("idle off", out, 19'h00000);
        tx.press(10'h000, 1'b1);
        check("on again", out, 19'h40000);
        link = 1'b0;
        cyc(3);
        check("link loss", out, 19'h00000);
        link = 1'b1;
    endtask

    task automatic t_tout();
        do_reset(1'b0);
        setup_req();
        cyc(310);
        check("timeout", {sgrn, lgrn}, 2'h0);
        setup_req();
        check("setup again", sgrn, 1'b1);
    endtask

    task automatic t_mode(input logic [NBTN-1:0] digit, input logic [1:0] exp);
        int n;
        do_reset(1'b1);
        tx.enter_cfg();
        n = nv_seen;
        tx.press(10'h004, 1'b0);
        tx.press(10'h001, 1'b0);
        tx.press(10'h008, 1'b0);
        tx.press(10'h002, 1'b0);
        tx.press(10'h000, 1'b1);
        tx.press(digit, 1'b0);
        cyc(2);
        check("mode wr", nv_seen, n + 1);
        check("mode", mode, exp);
    endtask

    task automatic t_auto();
        nv_md = 2'h2;
        do_reset(1'b1);
        check("nv mode", mode, 2'h2);
        tx.press(10'h000, 1'b1);
        check("auto on", out, 19'h40000);
        cyc(110);
        check("auto off", out, 19'h00000);
        nv_md = 2'h0;
    endtask

    task automatic t_secure();
        tx.send(10'h000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        tx.press(10'h000, 1'b1);
        check("secure locked", out, 19'h00000);
        tx.press(10'h004, 1'b0);
        tx.press(10'h001, 1'b0);
        tx.press(10'h008, 1'b0);
        tx.press(10'h002, 1'b0);
        tx.press(10'h000, 1'b1);
        check("secure on", out, 19'h40000);
    endtask

    initial
    begin
        link = 1'b1;
        setup = 1'b0;
        nv_md = 2'h0;
        nv_pd = 1'b0;
        mask = 19'h00000;
        nv_id = ID;
        t_pair();
        t_map();
        t_idle();
        t_tout();
        t_auto();
        t_mode(10'h001, 2'h0);
        t_mode(10'h008, 2'h1);
        t_secure();
        t_mode(10'h010, 2'h2);
        test_done();
    end

    initial
    begin
        cyc(6000);
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
